// file: hw/boost_cfg_pkg.sv
// Notes on behaviour
// - driver bits 7:6 set gate drive current, 00 weakest to 11 strongest.
// - adaptive bit 5 clear holds the target at the initial voltage code.
// - adaptive on starts at initial code, then tracks the highest string.
// - adaptive mode is forced off when every LED output is in cluster mode.
// - jump bit 4 clear allows only normal steps; set allows a jump command.
// - jump once brightness rise exceeds 10/30/50/70 percent, bits 3:2.
// - a jump raises the target by 8, 16, 32 or 64 steps from bits 1:0.
// - initial code is linear, 16 V at zero, 0.5 V per step, 47.5 V at top.
// - loop bits 7:6 set light-load threshold, lowest 00 to highest 11.
// - bits 5:4 select jitter filter: bypass, 300 kHz, 60 kHz, 30 kHz.
// - bits 3:2 set the integral gain, factors 1 to 4.
// - bits 1:0 set the proportional gain, factors 1 to 4.
package boost_cfg_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_DRIVER_JUMP = 8'h72;
    localparam logic [7:0] ADDR_START_VOLT  = 8'h73;
    localparam logic [7:0] ADDR_LOOP_COMP   = 8'h74;
    localparam logic [7:0] ADDR_TARGET_STAT = 8'h76;
    localparam logic [7:0] ADDR_CTRL_STAT   = 8'h77;

    localparam logic [7:0] RST_DRIVER_JUMP = 8'h00;
    localparam logic [7:0] RST_START_VOLT  = 8'h00;
    localparam logic [7:0] RST_LOOP_COMP   = 8'h00;
    localparam logic [7:0] START_VOLT_MASK = 8'h3F;

    // ==========================================================
    // field positions
    localparam int DRV_MSB  = 7;
    localparam int DRV_LSB  = 6;
    localparam int ADAP_BIT = 5;
    localparam int JUMP_BIT = 4;
    localparam int THR_MSB  = 3;
    localparam int THR_LSB  = 2;
    localparam int STEP_MSB = 1;
    localparam int STEP_LSB = 0;
    localparam int LLC_MSB  = 7;
    localparam int LLC_LSB  = 6;
    localparam int JIT_MSB  = 5;
    localparam int JIT_LSB  = 4;

    // ==========================================================
    // target scale
    localparam int          TGT_W       = 8;
    localparam logic [7:0]  TGT_MAX     = 8'hFF;
    localparam logic [7:0]  STEP_ONE    = 8'h01;
    localparam int          BRIGHT_W    = 16;
    localparam logic [15:0] BRIGHT_FULL = 16'hFFFF;
    localparam int          PCT_FULL    = 100;
    localparam int          NUM_STRINGS = 4;

    typedef struct packed {
        logic [1:0] driverStrength;
        logic       adaptiveVoltageEnable;
        logic       jumpEnable;
        logic [1:0] leapBrightnessThreshold;
        logic [1:0] jumpStepSize;
    } driver_jump_t;

    typedef struct packed {
        logic [1:0] lightLoadThreshold;
        logic [1:0] jitterFilter;
        logic [1:0] integralGain;
        logic [1:0] propGain;
    } loop_comp_t;

    typedef enum logic [2:0] {
        ST_FIXED = 3'h1,
        ST_START = 3'h2,
        ST_TRACK = 3'h4
    } mode_t;

    // jump step count: 8 << code
    function automatic logic [7:0] jumpSteps(input logic [1:0] code);
        case (code)
            2'h0:    jumpSteps = 8'h08;
            2'h1:    jumpSteps = 8'h10;
            2'h2:    jumpSteps = 8'h20;
            default: jumpSteps = 8'h40;
        endcase
    endfunction

    // brightness threshold in percent
    function automatic logic [6:0] jumpPercent(input logic [1:0] code);
        case (code)
            2'h0:    jumpPercent = 7'h0A;
            2'h1:    jumpPercent = 7'h1E;
            2'h2:    jumpPercent = 7'h32;
            default: jumpPercent = 7'h46;
        endcase
    endfunction

endpackage

// file: hw/jump_detect.sv
module jump_detect (
    input  wire logic                                  clock,
    input  wire logic                                  rst_n,
    input  wire logic [boost_cfg_pkg::BRIGHT_W-1:0]    brightness,
    input  wire logic [1:0]                            thresholdCode,
    input  wire logic                                  enable,
    output logic                                       jumpPulse
);
    // ==========================================================
    // brightness rise detector
    logic [boost_cfg_pkg::BRIGHT_W-1:0] lastBright_q;
    logic [23:0]                        riseScaled;
    logic [23:0]                        limitScaled;

    // compare rise*100 against threshold% of full scale, no divider
    always_comb begin
        riseScaled  = 24'h000000;
        limitScaled = 24'(boost_cfg_pkg::jumpPercent(thresholdCode))
                    * 24'(boost_cfg_pkg::BRIGHT_FULL);
        if (brightness > lastBright_q) begin
            riseScaled = 24'(brightness - lastBright_q)
                       * 24'(boost_cfg_pkg::PCT_FULL);
        end
    end

    // reference follows brightness after a jump, on a fall or when disabled,
    // so slow ramps accumulate until they cross the threshold
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lastBright_q <= 16'h0000;
            jumpPulse    <= 1'b0;
        end else begin
            jumpPulse <= 1'b0;
            if (!enable || brightness < lastBright_q) begin
                lastBright_q <= brightness;
            end else if (riseScaled > limitScaled) begin
                jumpPulse    <= 1'b1;
                lastBright_q <= brightness;
            end
        end
    end
endmodule

// file: hw/boost_voltage_loop_config.sv
module boost_voltage_loop_config (
    input  wire logic                                clock,
    input  wire logic                                rst_n,
    // classic wishbone slave
    input  wire logic                                wb_cyc_i,
    input  wire logic                                wb_stb_i,
    input  wire logic                                wb_we_i,
    input  wire logic [7:0]                          wb_adr_i,
    input  wire logic [3:0]                          wb_sel_i,
    input  wire logic [31:0]                         wb_dat_i,
    output logic [31:0]                              wb_dat_o,
    output logic                                     wb_ack_o,
    output logic                                     wb_err_o,
    // status from the LED channels and dimming path
    input  wire logic [boost_cfg_pkg::NUM_STRINGS-1:0] clusterMode,
    input  wire logic [boost_cfg_pkg::BRIGHT_W-1:0]  brightness,
    input  wire logic                                headroomLow,
    input  wire logic                                headroomHigh,
    input  wire logic                                stepTick,
    // settings to the power stage
    output logic [1:0]                               gateDriveStrength,
    output logic [boost_cfg_pkg::TGT_W-1:0]          boostTarget,
    output logic                                     adaptiveActive,
    output logic                                     jumpIssued,
    output logic [1:0]                               lightLoadThreshold,
    output logic [1:0]                               jitterFilter,
    output logic [2:0]                               integralGain,
    output logic [2:0]                               propGain
);
    // ==========================================================
    // pin synchronisers
    logic [boost_cfg_pkg::NUM_STRINGS-1:0] clusterMeta_q;
    logic [boost_cfg_pkg::NUM_STRINGS-1:0] clusterSync_q;
    logic [2:0]                            flagMeta_q;
    logic [2:0]                            flagSync_q;
    logic [boost_cfg_pkg::BRIGHT_W-1:0]    brightMeta_q;
    logic [boost_cfg_pkg::BRIGHT_W-1:0]    brightSync_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clusterMeta_q <= '0;
            clusterSync_q <= '0;
            flagMeta_q    <= 3'h0;
            flagSync_q    <= 3'h0;
            brightMeta_q  <= 16'h0000;
            brightSync_q  <= 16'h0000;
        end else begin
            clusterMeta_q <= clusterMode;
            clusterSync_q <= clusterMeta_q;
            flagMeta_q    <= {stepTick, headroomHigh, headroomLow};
            flagSync_q    <= flagMeta_q;
            // brightness assumed quasi-static vs 50 ns clock
            brightMeta_q  <= brightness;
            brightSync_q  <= brightMeta_q;
        end
    end

    logic tickPrev_q;
    logic tickPulse;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tickPrev_q <= 1'b0;
        end else begin
            tickPrev_q <= flagSync_q[2];
        end
    end
    assign tickPulse = flagSync_q[2] & ~tickPrev_q;

    // ==========================================================
    // register file
    boost_cfg_pkg::driver_jump_t driverJump_q;
    boost_cfg_pkg::loop_comp_t   loopComp_q;
    logic [5:0]                  startVolt_q;
    boost_cfg_pkg::mode_t        mode_q;
    logic                        jumpSeen_q;
    logic                        busReq;
    logic                        wrLane0;
    logic                        validAddr;

    assign busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    // write lands on the edge where the master samples ack
    assign wrLane0 = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

    function automatic logic addrHit(input logic [7:0] a);
        addrHit = (a == boost_cfg_pkg::ADDR_DRIVER_JUMP)
               || (a == boost_cfg_pkg::ADDR_START_VOLT)
               || (a == boost_cfg_pkg::ADDR_LOOP_COMP)
               || (a == boost_cfg_pkg::ADDR_TARGET_STAT)
               || (a == boost_cfg_pkg::ADDR_CTRL_STAT);
    endfunction
    assign validAddr = addrHit(wb_adr_i);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            driverJump_q <= boost_cfg_pkg::RST_DRIVER_JUMP;
            loopComp_q   <= boost_cfg_pkg::RST_LOOP_COMP;
            startVolt_q  <= boost_cfg_pkg::RST_START_VOLT[5:0];
        end else if (wrLane0) begin
            case (wb_adr_i)
                boost_cfg_pkg::ADDR_DRIVER_JUMP: begin
                    driverJump_q <= wb_dat_i[7:0];
                end
                boost_cfg_pkg::ADDR_START_VOLT: begin
                    startVolt_q <= wb_dat_i[5:0];
                end
                boost_cfg_pkg::ADDR_LOOP_COMP: begin
                    loopComp_q <= wb_dat_i[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // bus answer, registered one cycle after the request
    logic [7:0] readByte;
    always_comb begin
        case (wb_adr_i)
            boost_cfg_pkg::ADDR_DRIVER_JUMP: readByte = driverJump_q;
            boost_cfg_pkg::ADDR_START_VOLT:
                readByte = {2'h0, startVolt_q}
                         & boost_cfg_pkg::START_VOLT_MASK;
            boost_cfg_pkg::ADDR_LOOP_COMP:   readByte = loopComp_q;
            boost_cfg_pkg::ADDR_TARGET_STAT: readByte = boostTarget;
            boost_cfg_pkg::ADDR_CTRL_STAT:
                readByte = {5'h00, jumpSeen_q,
                            mode_q == boost_cfg_pkg::ST_TRACK,
                            adaptiveActive};
            default:                         readByte = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq & validAddr;
            wb_err_o <= busReq & ~validAddr;
            wb_dat_o <= busReq ? {24'h000000, readByte} : 32'h00000000;
        end
    end

    // ==========================================================
    // adaptive mode control
    logic adaptAllowed;
    logic jumpPulse;

    // all strings clustered disables adaptation whatever bit 5 says
    assign adaptAllowed = driverJump_q.adaptiveVoltageEnable
                        & ~(&clusterSync_q);

    jump_detect jumpDet (
        .clock         (clock),
        .rst_n         (rst_n),
        .brightness    (brightSync_q),
        .thresholdCode (driverJump_q.leapBrightnessThreshold),
        .enable        (adaptAllowed & driverJump_q.jumpEnable),
        .jumpPulse     (jumpPulse)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= boost_cfg_pkg::ST_FIXED;
        end else begin
            case (mode_q)
                boost_cfg_pkg::ST_FIXED: begin
                    if (adaptAllowed) begin
                        mode_q <= boost_cfg_pkg::ST_START;
                    end
                end
                boost_cfg_pkg::ST_START: begin
                    if (!adaptAllowed) begin
                        mode_q <= boost_cfg_pkg::ST_FIXED;
                    end else begin
                        mode_q <= boost_cfg_pkg::ST_TRACK;
                    end
                end
                boost_cfg_pkg::ST_TRACK: begin
                    if (!adaptAllowed) begin
                        mode_q <= boost_cfg_pkg::ST_FIXED;
                    end
                end
                default: mode_q <= boost_cfg_pkg::ST_FIXED;
            endcase
        end
    end

    // ==========================================================
    // voltage target, 16 V + 0.5 V per code
    logic [8:0] raised;
    logic [7:0] stepUp;
    logic [7:0] startCode;

    assign startCode = {2'h0, startVolt_q};
    assign stepUp    = jumpPulse
                     ? boost_cfg_pkg::jumpSteps(driverJump_q.jumpStepSize)
                     : boost_cfg_pkg::STEP_ONE;
    assign raised    = {1'b0, boostTarget} + {1'b0, stepUp};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            boostTarget <= 8'h00;
        end else if (mode_q != boost_cfg_pkg::ST_TRACK) begin
            boostTarget <= startCode;
        end else if (jumpPulse) begin
            // saturate at top of scale
            boostTarget <= raised[8] ? boost_cfg_pkg::TGT_MAX
                                     : raised[7:0];
        end else if (tickPulse && flagSync_q[0]) begin
            // headroom short on weakest string: one normal step up
            boostTarget <= raised[8] ? boost_cfg_pkg::TGT_MAX
                                     : raised[7:0];
        end else if (tickPulse && flagSync_q[1]
                     && boostTarget > startCode) begin
            boostTarget <= boostTarget - boost_cfg_pkg::STEP_ONE;
        end
    end

    // ==========================================================
    // static settings to the analogue stage, plus adaptive and jump status flags
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gateDriveStrength  <= 2'h0;
            lightLoadThreshold <= 2'h0;
            jitterFilter       <= 2'h0;
            integralGain       <= 3'h1;
            propGain           <= 3'h1;
            adaptiveActive     <= 1'b0;
            jumpIssued         <= 1'b0;
            jumpSeen_q         <= 1'b0;
        end else begin
            gateDriveStrength  <= driverJump_q.driverStrength;
            lightLoadThreshold <= loopComp_q.lightLoadThreshold;
            jitterFilter       <= loopComp_q.jitterFilter;
            // gain factor is code plus one
            integralGain <= {1'b0, loopComp_q.integralGain} + 3'h1;
            propGain     <= {1'b0, loopComp_q.propGain} + 3'h1;
            adaptiveActive     <= adaptAllowed;
            jumpIssued         <= jumpPulse
                                & (mode_q == boost_cfg_pkg::ST_TRACK);
            if (jumpPulse && mode_q == boost_cfg_pkg::ST_TRACK) begin
                jumpSeen_q <= 1'b1;
            end else if (wrLane0
                         && wb_adr_i == boost_cfg_pkg::ADDR_CTRL_STAT
                         && wb_dat_i[2]) begin
                jumpSeen_q <= 1'b0;
            end
        end
    end
endmodule

// file: verification/boost_voltage_loop_config_properties.sv
// ==========================================================
// checker on the top ports
module boost_voltage_loop_config_properties (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic [3:0]  clusterMode,
    input wire logic [1:0]  gateDriveStrength,
    input wire logic [7:0]  boostTarget,
    input wire logic        adaptiveActive,
    input wire logic [1:0]  lightLoadThreshold,
    input wire logic [1:0]  jitterFilter,
    input wire logic [2:0]  integralGain,
    input wire logic [2:0]  propGain
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wrAny;
    logic wrDrv;
    logic wrStart;
    logic wrLoop;
    assign wrAny = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign wrDrv = wrAny && wb_adr_i == boost_cfg_pkg::ADDR_DRIVER_JUMP;
    assign wrStart = wrAny && wb_adr_i == boost_cfg_pkg::ADDR_START_VOLT;
    assign wrLoop = wrAny && wb_adr_i == boost_cfg_pkg::ADDR_LOOP_COMP;

    // ==========================================================
    // properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    bus_answer_a:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
            |=> wb_ack_o != wb_err_o) else $error("no single answer");
    gate_drive_a:
        assert property (wrDrv |-> ##2 gateDriveStrength
            == $past(wb_dat_i[7:6], 2)) else $error("gate drive wrong");
    loop_select_a:
        assert property (wrLoop |-> ##2 {lightLoadThreshold, jitterFilter}
            == $past(wb_dat_i[7:4], 2)) else $error("loop field wrong");
    gain_code_a:
        assert property (wrLoop |-> ##2
            integralGain - 3'h1 == {1'b0, $past(wb_dat_i[3:2], 2)} &&
            propGain - 3'h1 == {1'b0, $past(wb_dat_i[1:0], 2)})
            else $error("gain factor wrong");
    reserved_zero_a:
        assert property (wb_ack_o && !wb_we_i && wb_adr_i ==
            boost_cfg_pkg::ADDR_START_VOLT |-> wb_dat_o[31:6] == 26'h0)
            else $error("reserved bits not zero");
    cluster_off_a:
        assert property ((&clusterMode)[*5] |-> !adaptiveActive)
            else $error("adaptive left on in cluster mode");
    fixed_hold_a:
        assert property ((!adaptiveActive && !wb_ack_o)[*4]
            |=> $stable(boostTarget)) else $error("fixed target moved");
    start_code_a:
        assert property (wrStart && !adaptiveActive |-> ##2 boostTarget
            == {2'h0, $past(wb_dat_i[5:0], 2)})
            else $error("start code not applied");
endmodule

bind boost_voltage_loop_config boost_voltage_loop_config_properties chk (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .clusterMode(clusterMode),
    .gateDriveStrength(gateDriveStrength), .boostTarget(boostTarget),
    .adaptiveActive(adaptiveActive), .jitterFilter(jitterFilter),
    .lightLoadThreshold(lightLoadThreshold), .propGain(propGain),
    .integralGain(integralGain)
);

// file: verification/boost_voltage_loop_config_tb.sv
module boost_voltage_loop_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, rst_n, cyc, stb, we, ack, err;
    logic [7:0]  adr, target, expT;
    logic [3:0]  sel, cluster;
    logic [31:0] datW, datR, rd;
    logic [15:0] bright;
    logic        hdLow, hdHigh, tick, adaptive, jump, rdErr;
    logic [1:0]  gate, llc, jitter;
    logic [2:0]  gainI, gainP;
    int          fails = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          jumps = 0;
    int          lim;

    boost_voltage_loop_config dut (
        .clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
        .wb_dat_o(datR), .wb_ack_o(ack), .wb_err_o(err),
        .clusterMode(cluster), .brightness(bright), .headroomLow(hdLow),
        .headroomHigh(hdHigh), .stepTick(tick), .gateDriveStrength(gate),
        .boostTarget(target), .adaptiveActive(adaptive), .jumpIssued(jump),
        .lightLoadThreshold(llc), .jitterFilter(jitter),
        .integralGain(gainI), .propGain(gainP)
    );

    // ==========================================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge clock);
    endtask

    // called just after a rising edge; ends one idle cycle later
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        datW <= {24'h000000, d};
        do begin
            @(posedge clock);
        end while (ack !== 1'b1 && err !== 1'b1);
        rd = datR;
        rdErr = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clock);
    endtask

    // slow ticks so each edge survives the synchroniser
    task automatic pulse(input int k);
        repeat (k) begin
            tick <= 1'b1;
            idle(4);
            tick <= 1'b0;
            idle(4);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // clock, timeout and tests
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (jump === 1'b1) begin
            jumps <= jumps + 1;
        end
        if (cycles == 5000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        {cyc, stb, we, hdLow, hdHigh, tick} = 6'h00;
        adr = 8'h00;
        sel = 4'h1;
        datW = 32'h0;
        cluster = 4'h0;
        bright = 16'h0000;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check(gainI, 3'h1);
        check(gainP, 3'h1);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, boost_cfg_pkg::ADDR_DRIVER_JUMP + i[7:0], 8'h00);
            check(rd, 32'h0);
        end
        xfer(1'b0, 8'h75, 8'h00);
        check(rdErr, 1'b1);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, boost_cfg_pkg::ADDR_DRIVER_JUMP, {c[1:0], 6'h00});
            xfer(1'b1, boost_cfg_pkg::ADDR_LOOP_COMP, {4{c[1:0]}});
            idle(2);
            check(gate, c[1:0]);
            check(llc, c[1:0]);
            check(jitter, c[1:0]);
            check(gainI, c[2:0] + 3'h1);
            check(gainP, c[2:0] + 3'h1);
            xfer(1'b0, boost_cfg_pkg::ADDR_LOOP_COMP, 8'h00);
            check(rd, {24'h0, {4{c[1:0]}}});
        end
        $display("test fields done");
        xfer(1'b1, boost_cfg_pkg::ADDR_START_VOLT, 8'hFF);
        xfer(1'b0, boost_cfg_pkg::ADDR_START_VOLT, 8'h00);
        check(rd, 32'h3F);
        check(target, 8'h3F);
        xfer(1'b1, boost_cfg_pkg::ADDR_START_VOLT, 8'hC5);
        xfer(1'b0, boost_cfg_pkg::ADDR_START_VOLT, 8'h00);
        check(rd, 32'h05);
        hdLow <= 1'b1;
        cluster <= 4'hF;
        pulse(2);
        check(target, 8'h05);
        hdLow <= 1'b0;
        xfer(1'b1, boost_cfg_pkg::ADDR_DRIVER_JUMP, 8'h20);
        idle(6);
        check(adaptive, 1'b0);
        cluster <= 4'h7;
        idle(6);
        check(adaptive, 1'b1);
        check(target, 8'h05);
        hdLow <= 1'b1;
        pulse(3);
        check(target, 8'h08);
        hdLow <= 1'b0;
        hdHigh <= 1'b1;
        pulse(5);
        check(target, 8'h05);
        hdHigh <= 1'b0;
        $display("test adaptive done");
        // jump bit still clear: a full-scale rise must not jump
        bright <= 16'hFFFF;
        idle(10);
        check(target, 8'h05);
        check(jumps, 32'h0);
        bright <= 16'h0000;
        idle(10);
        expT = 8'h05;
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, boost_cfg_pkg::ADDR_DRIVER_JUMP,
                 {4'h3, c[1:0], c[1:0]});
            lim = (10 + 20 * c) * 65535 / 100;
            bright <= lim[15:0];
            idle(10);
            check(target, expT);
            bright <= lim[15:0] + 16'h0001;
            idle(10);
            expT = expT + (8'h08 << c);
            check(target, expT);
            bright <= 16'h0000;
            idle(10);
        end
        xfer(1'b0, boost_cfg_pkg::ADDR_TARGET_STAT, 8'h00);
        check(rd, {24'h0, expT});
        check(jumps, 32'h4);
        xfer(1'b0, boost_cfg_pkg::ADDR_CTRL_STAT, 8'h00);
        check(rd[2:0], 3'h7);
        xfer(1'b1, boost_cfg_pkg::ADDR_CTRL_STAT, 8'h04);
        xfer(1'b0, boost_cfg_pkg::ADDR_CTRL_STAT, 8'h00);
        check(rd[2:0], 3'h3);
        $display("test jump done");
        stop_test();
    end
endmodule
